/* File: hdl/evc_event_counter.sv */
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "evc_defines.svh"
// Behaviour
// - Edge code 00 counts falling low-pin edges.
// - Clock code 00 takes low pin clock.
// - Bit 7 flags high counter overflow.
// - Bit 6 flags low counter overflow when split.
// - Bit 4 joins or splits the counters.
// - Bit 3 gates high counter clock.
// - Bit 2 gates low counter clock.
// - Bit 1 low holds high counter reset.
// - Bit 0 low holds low counter reset.
// - High count readable, upper byte when joined.
// - Low count readable, lower byte when joined.
// - Overflow sets the interrupt request flag.
// - Enable bit gates request onto interrupt.
// - Function bit routes shared pin to counter.
// - Joined overflow flags, wraps both to zero.
// - Request flag sticks; software writes zero.
// - High clock: own pin or low overflow.
module evc_event_counter (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic highEventPin,
  input wire logic sharedPortPinIn,
  output logic sharedPortPinOut,
  output logic sharedPortPinOe,
  output logic irq
);
  // ==========================================================================
  // Registers.
  evc_pkg::evc_ctrl_stat_t ctrl_reg;
  logic [7:0] edgeSel_reg;
  logic [7:0] clkCtrl_reg;
  logic [7:0] pinFunc_reg;
  logic [7:0] irqEnable_reg;
  logic irqRequest_reg;
  logic [1:0] portDrive_reg;
  logic [7:0] highCount_reg;
  logic [7:0] lowCount_reg;
  logic lowSync1_reg, lowSync2_reg, lowPrev_reg;
  logic highSync1_reg, highSync2_reg, highPrev_reg;
  logic pinSync1_reg, pinSync2_reg;
  logic awHeld_reg, wHeld_reg;
  logic [15:0] awIndex_reg;
  logic [7:0] wData_reg;
  logic wLane0_reg;
  logic [1:0] bresp_reg;
  logic bvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rvalid_reg;

  // ==========================================================================
  // Pin synchronisers and edge detection.
  // Counting on ref_clk keeps every count and flag in one domain, so reads
  // are always coherent; the price is a pin rate limited to below half of ref_clk.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lowSync1_reg <= 1'b1;
      lowSync2_reg <= 1'b1;
      lowPrev_reg <= 1'b1;
      highSync1_reg <= 1'b1;
      highSync2_reg <= 1'b1;
      highPrev_reg <= 1'b1;
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
    end else begin
      lowSync1_reg <= sharedPortPinIn;
      lowSync2_reg <= lowSync1_reg;
      lowPrev_reg <= lowSync2_reg;
      highSync1_reg <= highEventPin;
      highSync2_reg <= highSync1_reg;
      highPrev_reg <= highSync2_reg;
      pinSync1_reg <= sharedPortPinIn;
      pinSync2_reg <= pinSync1_reg;
    end
  end

  function automatic logic edgeHit(input logic [1:0] sel, input logic cur, input logic prev);
    logic hit;
    hit = 1'b0;
    case (sel)
      `EVC_EDGE_FALL: hit = prev && !cur;
      `EVC_EDGE_RISE: hit = !prev && cur;
      default: hit = prev ^ cur;
    endcase
    return hit;
  endfunction : edgeHit

  logic pinIsEvent;
  logic lowEdge, highEdge, lowTick, lowOverflow, highSource, highTick, highOverflow;
  assign pinIsEvent = pinFunc_reg[`EVC_PIN_FUNC_BIT];
  assign lowEdge = pinIsEvent && (clkCtrl_reg[`EVC_LOW_CLK_MSB:`EVC_LOW_CLK_LSB] == `EVC_CLK_FROM_PIN)
    && edgeHit(edgeSel_reg[`EVC_LOW_EDGE_MSB:`EVC_LOW_EDGE_LSB], lowSync2_reg, lowPrev_reg);
  assign lowTick = lowEdge && ctrl_reg.lowCountUpEnable && ctrl_reg.lowResetRelease;
  assign lowOverflow = lowTick && (lowCount_reg == `EVC_COUNT_FULL);
  assign highEdge = edgeHit(edgeSel_reg[`EVC_HIGH_EDGE_MSB:`EVC_HIGH_EDGE_LSB], highSync2_reg, highPrev_reg);
  assign highSource = ctrl_reg.channelSplit ? highEdge : lowOverflow;
  assign highTick = highSource && ctrl_reg.highCountUpEnable && ctrl_reg.highResetRelease;
  assign highOverflow = highTick && (highCount_reg == `EVC_COUNT_FULL);

  // ==========================================================================
  // Counters.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lowCount_reg <= `EVC_COUNT_RESET;
    end else if (!ctrl_reg.lowResetRelease) begin
      lowCount_reg <= `EVC_COUNT_RESET;
    end else if (lowTick) begin
      lowCount_reg <= lowCount_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      highCount_reg <= `EVC_COUNT_RESET;
    end else if (!ctrl_reg.highResetRelease) begin
      highCount_reg <= `EVC_COUNT_RESET;
    end else if (highTick) begin
      highCount_reg <= highCount_reg + 8'h01;
    end
  end

  // ==========================================================================
  // Register bus, write side. Address and data are taken in either order.
  logic doWrite, wrLane;
  assign s_axi_awready = !awHeld_reg && !bvalid_reg;
  assign s_axi_wready = !wHeld_reg && !bvalid_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  assign wrLane = doWrite && wLane0_reg;

  function automatic logic mapped(input logic [15:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      `EVC_IDX_EDGE_SEL, `EVC_IDX_CLK_CTRL, `EVC_IDX_CTRL_STAT, `EVC_IDX_COUNT_HIGH,
      `EVC_IDX_COUNT_LOW, `EVC_IDX_PORT_DRIVE, `EVC_IDX_PIN_FUNC, `EVC_IDX_IRQ_ENABLE,
      `EVC_IDX_IRQ_REQUEST: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : mapped

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awIndex_reg <= 16'h0000;
      wData_reg <= 8'h00;
      wLane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `EVC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awIndex_reg <= s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata[7:0];
        wLane0_reg <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(awIndex_reg) ? `EVC_RESP_OKAY : `EVC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ==========================================================================
  // Software registers.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      edgeSel_reg <= `EVC_REG_RESET;
      clkCtrl_reg <= `EVC_REG_RESET;
      pinFunc_reg <= `EVC_REG_RESET;
      irqEnable_reg <= `EVC_REG_RESET;
      portDrive_reg <= 2'h0;
    end else if (wrLane) begin
      case (awIndex_reg)
        `EVC_IDX_EDGE_SEL: edgeSel_reg <= wData_reg;
        `EVC_IDX_CLK_CTRL: clkCtrl_reg <= wData_reg;
        `EVC_IDX_PIN_FUNC: pinFunc_reg <= wData_reg;
        `EVC_IDX_IRQ_ENABLE: irqEnable_reg <= wData_reg;
        `EVC_IDX_PORT_DRIVE: portDrive_reg <= wData_reg[1:0];
        default: ;
      endcase
    end
  end

  // Flags clear on a written zero; a same-cycle overflow still sets them.
  logic wrCtrl, wrIrq;
  assign wrCtrl = wrLane && (awIndex_reg == `EVC_IDX_CTRL_STAT);
  assign wrIrq = wrLane && (awIndex_reg == `EVC_IDX_IRQ_REQUEST);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= evc_pkg::evc_ctrl_stat_t'(`EVC_REG_RESET);
    end else begin
      if (wrCtrl) begin
        ctrl_reg.channelSplit <= wData_reg[4];
        ctrl_reg.highCountUpEnable <= wData_reg[3];
        ctrl_reg.lowCountUpEnable <= wData_reg[2];
        ctrl_reg.highResetRelease <= wData_reg[1];
        ctrl_reg.lowResetRelease <= wData_reg[0];
      end
      ctrl_reg.highOverflow <= highOverflow || (ctrl_reg.highOverflow && !(wrCtrl && !wData_reg[7]));
      ctrl_reg.lowOverflow <= (lowOverflow && ctrl_reg.channelSplit)
        || (ctrl_reg.lowOverflow && !(wrCtrl && !wData_reg[6]));
    end
  end

  // ==========================================================================
  // Interrupt.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irqRequest_reg <= 1'b0;
    end else begin
      irqRequest_reg <= highOverflow || (lowOverflow && ctrl_reg.channelSplit)
        || (irqRequest_reg && !(wrIrq && !wData_reg[`EVC_IRQ_BIT]));
    end
  end
  assign irq = irqRequest_reg && irqEnable_reg[`EVC_IRQ_BIT];

  // ==========================================================================
  // Shared pin as a plain port when not routed to the counter.
  assign sharedPortPinOut = portDrive_reg[`EVC_DRIVE_LEVEL_BIT];
  assign sharedPortPinOe = !pinIsEvent && portDrive_reg[`EVC_DRIVE_EN_BIT];

  // ==========================================================================
  // Register bus, read side.
  logic [7:0] readByte;
  always_comb begin
    readByte = 8'h00;
    case (s_axi_araddr[17:2])
      `EVC_IDX_EDGE_SEL: readByte = edgeSel_reg;
      `EVC_IDX_CLK_CTRL: readByte = clkCtrl_reg;
      `EVC_IDX_CTRL_STAT: readByte = {ctrl_reg.highOverflow, ctrl_reg.lowOverflow, 1'b0, ctrl_reg[4:0]};
      `EVC_IDX_COUNT_HIGH: readByte = highCount_reg;
      `EVC_IDX_COUNT_LOW: readByte = lowCount_reg;
      `EVC_IDX_PORT_DRIVE: readByte = {5'h00, pinSync2_reg, portDrive_reg};
      `EVC_IDX_PIN_FUNC: readByte = pinFunc_reg;
      `EVC_IDX_IRQ_ENABLE: readByte = irqEnable_reg;
      `EVC_IDX_IRQ_REQUEST: readByte = {7'h00, irqRequest_reg};
      default: readByte = 8'h00;
    endcase
  end

  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `EVC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, readByte};
      rresp_reg <= mapped(s_axi_araddr[17:2]) ? `EVC_RESP_OKAY : `EVC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  lowFallCount_a: assert property (pinIsEvent && edgeSel_reg[5:4] == 2'h0 && clkCtrl_reg[5:4] == 2'h0
      && ctrl_reg.lowCountUpEnable && ctrl_reg.lowResetRelease && lowPrev_reg && !lowSync2_reg
      |=> lowCount_reg == 8'($past(lowCount_reg) + 8'h01))
    else $error("falling edge did not count");
  clkSelBlock_a: assert property (clkCtrl_reg[5:4] != 2'h0 && ctrl_reg.lowResetRelease
      |=> $stable(lowCount_reg))
    else $error("low counter moved with no pin clock");
  highOvfFlag_a: assert property (highOverflow |=> ctrl_reg.highOverflow && highCount_reg == 8'h00)
    else $error("high overflow not flagged");
  lowOvfFlag_a: assert property (lowOverflow && ctrl_reg.channelSplit |=> ctrl_reg.lowOverflow)
    else $error("low overflow not flagged");
  joinedCarry_a: assert property (!ctrl_reg.channelSplit && lowOverflow && ctrl_reg.highCountUpEnable
      && ctrl_reg.highResetRelease |=> highCount_reg == 8'($past(highCount_reg) + 8'h01))
    else $error("carry did not reach high counter");
  highGate_a: assert property (!ctrl_reg.highCountUpEnable && ctrl_reg.highResetRelease
      |=> $stable(highCount_reg))
    else $error("high counter moved while gated");
  lowGate_a: assert property (!ctrl_reg.lowCountUpEnable && ctrl_reg.lowResetRelease
      |=> $stable(lowCount_reg))
    else $error("low counter moved while gated");
  highHeld_a: assert property (!ctrl_reg.highResetRelease |=> highCount_reg == 8'h00)
    else $error("high counter not held in reset");
  lowHeld_a: assert property (!ctrl_reg.lowResetRelease |=> lowCount_reg == 8'h00)
    else $error("low counter not held in reset");
  highRead_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[17:2] == 16'hFF96
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(highCount_reg)})
    else $error("high count read wrong");
  irqSet_a: assert property (highOverflow |=> irqRequest_reg)
    else $error("request flag not set");
  irqSticky_a: assert property (irqRequest_reg && !wrIrq |=> irqRequest_reg)
    else $error("request flag dropped by itself");
  irqOut_a: assert property (irqRequest_reg && irqEnable_reg[0] |-> irq)
    else $error("enabled request not raised");
  pinRoute_a: assert property (pinIsEvent |-> !sharedPortPinOe)
    else $error("event pin driven");
  lowRead_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[17:2] == `EVC_IDX_COUNT_LOW
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(lowCount_reg)})
    else $error("low count read wrong");
  joinedWrap_a: assert property (!ctrl_reg.channelSplit && highOverflow
      |=> ctrl_reg.highOverflow && highCount_reg == 8'h00 && lowCount_reg == 8'h00)
    else $error("joined counter did not wrap to zero");
  splitHigh_a: assert property (ctrl_reg.channelSplit && highEdge && ctrl_reg.highCountUpEnable
      && ctrl_reg.highResetRelease |=> highCount_reg == 8'($past(highCount_reg) + 8'h01))
    else $error("high pin edge did not count");

  joinedWrap_c: cover property (!ctrl_reg.channelSplit && highOverflow);
  splitOverflow_c: cover property (ctrl_reg.channelSplit && lowOverflow);
  irqRaise_c: cover property (!irq ##1 irq);
endmodule : evc_event_counter

/* File: hdl/evc_defines.svh */
`ifndef EVC_DEFINES_SVH
`define EVC_DEFINES_SVH
// ==========================================================================
// Register indices; the byte address is four times the index.
`define EVC_IDX_EDGE_SEL 16'hFF92
`define EVC_IDX_CLK_CTRL 16'hFF94
`define EVC_IDX_CTRL_STAT 16'hFF95
`define EVC_IDX_COUNT_HIGH 16'hFF96
`define EVC_IDX_COUNT_LOW 16'hFF97
`define EVC_IDX_PORT_DRIVE 16'hFF98
`define EVC_IDX_PIN_FUNC 16'hFFCA
`define EVC_IDX_IRQ_ENABLE 16'hFFF4
`define EVC_IDX_IRQ_REQUEST 16'hFFF7
// ==========================================================================
// Field positions.
`define EVC_LOW_EDGE_MSB 5
`define EVC_LOW_EDGE_LSB 4
`define EVC_HIGH_EDGE_MSB 7
`define EVC_HIGH_EDGE_LSB 6
`define EVC_LOW_CLK_MSB 5
`define EVC_LOW_CLK_LSB 4
`define EVC_PIN_FUNC_BIT 7
`define EVC_IRQ_BIT 0
`define EVC_DRIVE_LEVEL_BIT 0
`define EVC_DRIVE_EN_BIT 1
`define EVC_DRIVE_PIN_BIT 2
// ==========================================================================
// Reset values and codes.
`define EVC_REG_RESET 8'h00
`define EVC_COUNT_RESET 8'h00
`define EVC_COUNT_FULL 8'hFF
`define EVC_EDGE_FALL 2'h0
`define EVC_EDGE_RISE 2'h1
`define EVC_CLK_FROM_PIN 2'h0
`define EVC_RESP_OKAY 2'h0
`define EVC_RESP_SLVERR 2'h2
`endif

/* File: hdl/evc_pkg.sv */
// ==========================================================================
// Types shared by the event counter.
package evc_pkg;
  typedef struct packed {
    logic highOverflow;
    logic lowOverflow;
    logic reserved5;
    logic channelSplit;
    logic highCountUpEnable;
    logic lowCountUpEnable;
    logic highResetRelease;
    logic lowResetRelease;
  } evc_ctrl_stat_t;
endpackage : evc_pkg

/* File: tb/evc_event_source.sv */
`timescale 1ns/100ps
// ==========================================================================
// Event source on the far side of the count pins.
module evc_event_source (
  output logic lowPin,
  output logic highPin
);
  initial begin
    lowPin = 1'b1;
    highPin = 1'b1;
  end
  // Each pulse is one low and one high phase of the 200 ns link period, so it
  // gives exactly one falling and one rising edge. A trailing idle phase lets
  // the synchroniser finish before the caller reads the counters.
  // The short lead-in keeps every pin change clear of a ref_clk edge.
  task automatic pulse(input logic onHigh, input int n);
    #5;
    repeat (n) begin
      if (onHigh) highPin = 1'b0;
      else lowPin = 1'b0;
      #100;
      if (onHigh) highPin = 1'b1;
      else lowPin = 1'b1;
      #100;
    end
    #100;
  endtask : pulse
endmodule : evc_event_source

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`include "evc_defines.svh"
// ==========================================================================
// Bench for the event counter.
module testbench;
  localparam logic [15:0] EDG = `EVC_IDX_EDGE_SEL;
  localparam logic [15:0] CST = `EVC_IDX_CTRL_STAT;
  localparam logic [15:0] CHI = `EVC_IDX_COUNT_HIGH;
  localparam logic [15:0] CLO = `EVC_IDX_COUNT_LOW;
  localparam logic [15:0] PFN = `EVC_IDX_PIN_FUNC;
  localparam logic [15:0] IEN = `EVC_IDX_IRQ_ENABLE;
  localparam logic [15:0] IRQ = `EVC_IDX_IRQ_REQUEST;
  localparam logic [1:0] OK = `EVC_RESP_OKAY;
  logic ref_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic lowSrc, highEventPin, sharedPortPinIn, sharedPortPinOut, sharedPortPinOe;
  int errorCnt = 0;
  int samplesChecked = 0;
  int cycleCnt = 0;
  // The shared pin is driven by the block when enabled, else by the source.
  assign sharedPortPinIn = sharedPortPinOe ? sharedPortPinOut : lowSrc;
  evc_event_counter dut (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .highEventPin,
    .sharedPortPinIn, .sharedPortPinOut, .sharedPortPinOe, .irq);
  evc_event_source src (.lowPin(lowSrc), .highPin(highEventPin));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // The longest scenario needs about 4200 cycles; the ceiling leaves ample room.
  always @(posedge ref_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 40000) begin
      errorCnt++;
      report_and_stop();
    end
  end
  // ==========================================================================
  // Shared tasks.
  task automatic report_and_stop;
    $display("TB: compared %0d, mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Ready is sampled at the falling edge, so the value seen is the one the
  // next rising edge acts on, free of any race with the slave's own update.
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic ta, tw, rb;
    logic [1:0] resp;
    rb = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!rb) begin
      @(negedge ref_clk);
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      rb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, resp}, {30'h0, OK});
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [7:0] expD, input logic [1:0] expR);
    logic ta, rv;
    logic [31:0] d;
    logic [1:0] resp;
    rv = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rv) begin
      @(negedge ref_clk);
      ta = s_axi_arready & s_axi_arvalid;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(d, {24'h0, expD});
    chk({30'h0, resp}, {30'h0, expR});
  endtask : rd
  task automatic chk_irq(input logic exp);
    @(negedge ref_clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : chk_irq
  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    rd(CST, 8'h00, OK);
    rd(CHI, 8'h00, OK);
    rd(CLO, 8'h00, OK);
    rd(IRQ, 8'h00, OK);
    rd(16'hFF93, 8'h00, `EVC_RESP_SLVERR);
    chk_irq(1'b0);
  endtask : t_reset
  task automatic t_edges;
    wr(PFN, 8'h80);
    for (int i = 0; i < 3; i++) begin
      wr(CST, 8'h00);
      wr(EDG, {2'h0, i[1:0], 4'h0});
      wr(CST, 8'h0F);
      src.pulse(1'b0, 2);
      rd(CLO, (i == 2) ? 8'h04 : 8'h02, OK);
    end
    wr(EDG, 8'h00);
    wr(`EVC_IDX_CLK_CTRL, 8'h10);
    src.pulse(1'b0, 2);
    rd(CLO, 8'h04, OK);
    rd(`EVC_IDX_CLK_CTRL, 8'h10, OK);
    wr(`EVC_IDX_CLK_CTRL, 8'h00);
  endtask : t_edges
  // Joined mode: the low byte's wrap carries into the high byte.
  task automatic t_joined;
    wr(CST, 8'h00);
    wr(CST, 8'h0F);
    src.pulse(1'b0, 3);
    rd(CLO, 8'h03, OK);
    rd(CHI, 8'h00, OK);
    src.pulse(1'b0, 253);
    rd(CLO, 8'h00, OK);
    rd(CHI, 8'h01, OK);
    rd(CST, 8'h0F, OK);
  endtask : t_joined
  task automatic t_gates;
    src.pulse(1'b0, 5);
    wr(CST, 8'h0B);
    src.pulse(1'b0, 2);
    rd(CLO, 8'h05, OK);
    rd(CLO, 8'h05, OK);
    wr(CST, 8'h0E);
    rd(CLO, 8'h00, OK);
    rd(CHI, 8'h01, OK);
    wr(CST, 8'h0D);
    rd(CHI, 8'h00, OK);
    wr(CST, 8'h17);
    src.pulse(1'b1, 2);
    rd(CHI, 8'h00, OK);
  endtask : t_gates
  // Split mode: each channel wraps on its own and raises the request.
  task automatic t_split;
    wr(IEN, 8'h00);
    wr(CST, 8'h1F);
    src.pulse(1'b1, 256);
    rd(CHI, 8'h00, OK);
    rd(CST, 8'h9F, OK);
    rd(CLO, 8'h00, OK);
    rd(IRQ, 8'h01, OK);
    chk_irq(1'b0);
    wr(IEN, 8'h01);
    chk_irq(1'b1);
    rd(IRQ, 8'h01, OK);
    wr(IRQ, 8'h00);
    rd(IRQ, 8'h00, OK);
    chk_irq(1'b0);
    wr(CST, 8'h1F);
    rd(CST, 8'h1F, OK);
    src.pulse(1'b0, 256);
    rd(CST, 8'h5F, OK);
    rd(IRQ, 8'h01, OK);
    wr(IRQ, 8'h00);
  endtask : t_split
  task automatic t_pinfunc;
    wr(PFN, 8'h00);
    src.pulse(1'b0, 2);
    rd(CLO, 8'h00, OK);
    wr(`EVC_IDX_PORT_DRIVE, 8'h03);
    @(negedge ref_clk);
    chk({30'h0, sharedPortPinOe, sharedPortPinOut}, 32'h3);
    rd(`EVC_IDX_PORT_DRIVE, 8'h07, OK);
  endtask : t_pinfunc
  // ==========================================================================
  // Main sequence.
  initial begin
    nrst = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_edges();
    t_joined();
    t_gates();
    t_split();
    t_pinfunc();
    report_and_stop();
  end
endmodule : testbench
